/* File: rtl/cmd_ctrl.sv */
// Link key change, piconet key select and peer name command engine
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Rekey command renews key at both ends
// - Handle twelve bits, 0x0F00 upward reserved
// - Master restarts encryption after temporary key rekey
// - Status, then key notice, then rekey complete
// - Never send generic command complete event
// - Key selector: zero semi-permanent, one temporary
// - Temporary key for broadcast, semi-permanent private
// - Both ends report piconet key select complete; a peer's is dropped unless idle with no event pending
// - Complete event carries link manager's handle
// - Name command: address, repeat, scan, offset
// - Repeat class above two is reserved
// - Scan mode above three is reserved
// - Offset low fifteen bits hold difference
// - Offset bit fifteen flags offset valid
// - No connection means temporary link for name
// - Status then exactly one name complete
// - Masked events are never delivered
module cmd_ctrl (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Avalon-MM register slave
  input wire logic [7:0] avm_address_in,
  input wire logic avm_read_in,
  input wire logic avm_write_in,
  input wire logic [31:0] avm_writedata_in,
  input wire logic [3:0] avm_byteenable_in,
  output logic [31:0] avm_readdata_out,
  output logic avm_waitrequest_out,
  // Link manager request
  output logic lm_req_out,
  output logic [15:0] lm_opcode_field_out,
  output logic [11:0] lm_handle_out,
  output logic [47:0] lm_device_address_out,
  output logic [7:0] lm_repeat_class_out,
  output logic [7:0] lm_scan_mode_out,
  output logic [14:0] lm_clock_offset_out,
  output logic lm_offset_valid_out,
  output logic lm_temp_link_out,
  output logic lm_key_temp_out,
  output logic enc_restart_out,
  // Link manager answer and link state
  input wire logic lm_done_in,
  input wire logic [7:0] lm_status_in,
  input wire logic [11:0] lm_handle_in,
  input wire logic is_master_in,
  input wire logic enc_active_in,
  input wire logic conn_exists_in,
  input wire logic peer_rekey_in,
  input wire logic peer_keysel_in,
  // Event pending level
  output logic evt_valid_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    cmd_pkg::fsm_t st;
    logic wreq;
    logic [31:0] rdata;
    logic [15:0] opc;
    logic [11:0] hdl;
    logic [7:0] kflag;
    logic [47:0] addr;
    logic [7:0] rep;
    logic [7:0] scan;
    logic [15:0] ofs;
    logic [4:0] mask;
    logic ev_v;
    logic [7:0] ev_code;
    logic [7:0] ev_stat;
    logic [11:0] ev_hdl;
    logic lm_req;
    logic [7:0] lm_stat;
    logic [11:0] lm_hdl;
    logic key_temp;
    logic enc_rst;
    logic tmp_link;
  } regs_t;

  regs_t s;
  regs_t n;
  logic known;
  logic cmd_ok;
  logic [31:0] rd;
  logic [31:0] w;
  logic [7:0] sts;
  logic wr_en;
  logic idle;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
    logic [31:0] o;
    o = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        o[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return o;
  endfunction : wmerge

  // Load one event unless the host masked its type
  function automatic regs_t emit(input regs_t r, input logic en,
                                 input logic [7:0] code,
                                 input logic [7:0] stat,
                                 input logic [11:0] hdl);
    regs_t o;
    o = r;
    if (en) begin
      o.ev_v = 1'b1;
      o.ev_code = code;
      o.ev_stat = stat;
      o.ev_hdl = hdl;
    end
    return o;
  endfunction : emit

  // Range check of the captured parameters
  cmd_param_check u_chk (
    .opc_in(s.opc),
    .hdl_in(s.hdl),
    .kflag_in(s.kflag),
    .rep_in(s.rep),
    .scan_in(s.scan),
    .known_out(known),
    .ok_out(cmd_ok)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = s;
    rd = '0;
    sts = cmd_pkg::STS_OK;
    idle = (s.st == cmd_pkg::S_IDLE);
    wr_en = avm_write_in && !s.wreq;
    n.enc_rst = 1'b0;
    // One wait cycle, then waitrequest low for exactly one cycle
    n.wreq = !((avm_read_in || avm_write_in) && s.wreq);
    // Read mux, latched as waitrequest drops
    case (avm_address_in)
      cmd_pkg::REG_CMD: begin
        rd[cmd_pkg::OPC_W-1:0] = s.opc;
        rd[cmd_pkg::CMD_BUSY_BIT] = !idle;
      end
      cmd_pkg::REG_HANDLE: rd[cmd_pkg::HDL_W-1:0] = s.hdl;
      cmd_pkg::REG_KEY: rd[cmd_pkg::BYTE_W-1:0] = s.kflag;
      cmd_pkg::REG_ADDR_LO: rd = s.addr[cmd_pkg::WORD_W-1:0];
      cmd_pkg::REG_ADDR_HI: rd[15:0] = s.addr[cmd_pkg::ADDR_W-1:cmd_pkg::WORD_W];
      cmd_pkg::REG_SCAN: begin
        rd[cmd_pkg::BYTE_W-1:0] = s.rep;
        rd[cmd_pkg::SCAN_LSB +: cmd_pkg::BYTE_W] = s.scan;
      end
      cmd_pkg::REG_OFS: rd[cmd_pkg::OPC_W-1:0] = s.ofs;
      cmd_pkg::REG_MASK: rd[cmd_pkg::MASK_W-1:0] = s.mask;
      cmd_pkg::REG_EVT: begin
        rd[cmd_pkg::EVT_VALID_BIT] = s.ev_v;
        rd[cmd_pkg::EVT_STAT_LSB +: cmd_pkg::BYTE_W] = s.ev_stat;
        rd[cmd_pkg::BYTE_W-1:0] = s.ev_code;
      end
      cmd_pkg::REG_EVT_HDL: rd[cmd_pkg::HDL_W-1:0] = s.ev_hdl;
      cmd_pkg::REG_STATE: begin
        rd[cmd_pkg::STATE_KEY_BIT] = s.key_temp;
        rd[cmd_pkg::STATE_FSM_LSB +: 3] = s.st;
      end
      default: rd = '0;
    endcase
    if (avm_read_in && s.wreq) begin
      n.rdata = rd;
    end
    // Writes land on the edge that sees waitrequest low; merging over the
    // read view keeps unwritten lanes. Parameters are frozen while a
    // command runs so the link manager sees stable values.
    w = wmerge(rd, avm_writedata_in, avm_byteenable_in);
    if (wr_en && idle) begin
      case (avm_address_in)
        cmd_pkg::REG_CMD: begin
          n.opc = w[cmd_pkg::OPC_W-1:0];
          n.st = cmd_pkg::S_STAT;
        end
        cmd_pkg::REG_HANDLE: n.hdl = w[cmd_pkg::HDL_W-1:0];
        cmd_pkg::REG_KEY: n.kflag = w[cmd_pkg::BYTE_W-1:0];
        cmd_pkg::REG_ADDR_LO: n.addr[cmd_pkg::WORD_W-1:0] = w;
        cmd_pkg::REG_ADDR_HI: n.addr[cmd_pkg::ADDR_W-1:cmd_pkg::WORD_W] = w[15:0];
        cmd_pkg::REG_SCAN: begin
          n.rep = w[cmd_pkg::BYTE_W-1:0];
          n.scan = w[cmd_pkg::SCAN_LSB +: cmd_pkg::BYTE_W];
        end
        cmd_pkg::REG_OFS: n.ofs = w[cmd_pkg::OPC_W-1:0];
        default: n.ev_v = n.ev_v;
      endcase
    end
    // Mask and event pop are taken while busy as well
    if (wr_en && (avm_address_in == cmd_pkg::REG_MASK)) begin
      n.mask = w[cmd_pkg::MASK_W-1:0];
    end
    // Any write here pops the pending event
    if (wr_en && (avm_address_in == cmd_pkg::REG_EVT)) begin
      n.ev_v = 1'b0;
    end
    // Sequencer: each command event waits until the previous one is popped,
    // which keeps the documented order without an event queue
    case (s.st)
      cmd_pkg::S_IDLE: begin
        // Peer initiated changes; they are dropped while busy
        if (!s.ev_v && peer_keysel_in) begin
          n = emit(n, s.mask[cmd_pkg::MB_MKEY], cmd_pkg::EVT_MKEY_DONE,
                   lm_status_in, lm_handle_in);
        end else if (!s.ev_v && peer_rekey_in) begin
          n = emit(n, s.mask[cmd_pkg::MB_NOTE], cmd_pkg::EVT_KEY_NOTE,
                   lm_status_in, lm_handle_in);
        end
      end
      cmd_pkg::S_STAT: begin
        if (!s.ev_v) begin
          if (!known) begin
            sts = cmd_pkg::STS_UNKNOWN;
          end else if (!cmd_ok) begin
            sts = cmd_pkg::STS_BAD_PARAM;
          end
          n = emit(n, s.mask[cmd_pkg::MB_STATUS], cmd_pkg::EVT_STATUS,
                   sts, s.hdl);
          n.lm_req = cmd_ok;
          n.tmp_link = cmd_ok && (s.opc == cmd_pkg::OPC_NAME)
                       && !conn_exists_in;
          n.st = cmd_ok ? cmd_pkg::S_LM : cmd_pkg::S_IDLE;
        end
      end
      cmd_pkg::S_LM: begin
        if (lm_done_in) begin
          n.lm_req = 1'b0;
          n.tmp_link = 1'b0;
          n.lm_stat = lm_status_in;
          n.lm_hdl = lm_handle_in;
          if (s.opc == cmd_pkg::OPC_KEYSEL && lm_status_in == cmd_pkg::STS_OK) begin
            n.key_temp = (s.kflag == cmd_pkg::KEY_TEMP);
          end
          if (s.opc == cmd_pkg::OPC_REKEY && lm_status_in == cmd_pkg::STS_OK) begin
            n.enc_rst = enc_active_in && s.key_temp && is_master_in;
            n.st = cmd_pkg::S_NOTE;
          end else begin
            n.st = cmd_pkg::S_DONE;
          end
        end
      end
      cmd_pkg::S_NOTE: begin
        if (!s.ev_v) begin
          n = emit(n, s.mask[cmd_pkg::MB_NOTE], cmd_pkg::EVT_KEY_NOTE,
                   s.lm_stat, s.hdl);
          n.st = cmd_pkg::S_DONE;
        end
      end
      cmd_pkg::S_DONE: begin
        // Only the command's own completion event, never a generic one
        if (!s.ev_v) begin
          case (s.opc)
            cmd_pkg::OPC_REKEY: n = emit(n, s.mask[cmd_pkg::MB_REKEY],
                                         cmd_pkg::EVT_REKEY_DONE,
                                         s.lm_stat, s.hdl);
            cmd_pkg::OPC_KEYSEL: n = emit(n, s.mask[cmd_pkg::MB_MKEY],
                                          cmd_pkg::EVT_MKEY_DONE,
                                          s.lm_stat, s.lm_hdl);
            default: n = emit(n, s.mask[cmd_pkg::MB_NAME],
                              cmd_pkg::EVT_NAME_DONE,
                              s.lm_stat, s.hdl);
          endcase
          n.st = cmd_pkg::S_IDLE;
        end
      end
      default: n.st = cmd_pkg::S_IDLE;
    endcase
  end

  // Register the whole state
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
      s.wreq <= 1'b1;
      s.mask <= cmd_pkg::MASK_RST;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs, all from flops
  // ----------------------------------------
  assign avm_readdata_out = s.rdata;
  assign avm_waitrequest_out = s.wreq;
  assign lm_req_out = s.lm_req;
  assign lm_opcode_field_out = s.opc;
  assign lm_handle_out = s.hdl;
  assign lm_device_address_out = s.addr;
  assign lm_repeat_class_out = s.rep;
  assign lm_scan_mode_out = s.scan;
  assign lm_clock_offset_out = s.ofs[cmd_pkg::OFS_W-1:0];
  assign lm_offset_valid_out = s.ofs[cmd_pkg::OFS_VALID_BIT];
  assign lm_temp_link_out = s.tmp_link;
  assign lm_key_temp_out = s.key_temp;
  assign enc_restart_out = s.enc_rst;
  assign evt_valid_out = s.ev_v;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  bus_answer_a: assert property ((avm_read_in || avm_write_in) && s.wreq
                                 |=> !avm_waitrequest_out ##1 avm_waitrequest_out)
    else $error("waitrequest did not drop for one cycle");
  bad_handle_a: assert property (s.st == cmd_pkg::S_STAT && !s.ev_v
                                 && s.opc == cmd_pkg::OPC_REKEY
                                 && s.hdl > cmd_pkg::HDL_MAX
                                 |=> !lm_req_out && s.st == cmd_pkg::S_IDLE)
    else $error("reserved handle reached link manager");
  enc_restart_a: assert property (enc_restart_out |-> $past(s.st) == cmd_pkg::S_LM
                                  && $past(s.opc) == cmd_pkg::OPC_REKEY && $past(s.key_temp)
                                  && $past(enc_active_in) && $past(is_master_in))
    else $error("encryption restart without cause");
  status_first_a: assert property ($rose(lm_req_out)
                                   |-> $past(s.st) == cmd_pkg::S_STAT)
    else $error("link request before status");
  no_generic_a: assert property (evt_valid_out
                                 |-> s.ev_code != cmd_pkg::EVT_CMD_DONE)
    else $error("generic complete event issued");
  key_select_a: assert property (s.st == cmd_pkg::S_LM && lm_done_in
                                 && s.opc == cmd_pkg::OPC_KEYSEL
                                 && lm_status_in == cmd_pkg::STS_OK
                                 |=> lm_key_temp_out
                                 == (s.kflag == cmd_pkg::KEY_TEMP))
    else $error("key selection not applied");
  mask_name_a: assert property ($rose(s.ev_v)
                                && s.ev_code == cmd_pkg::EVT_NAME_DONE
                                |-> $past(s.mask[cmd_pkg::MB_NAME]))
    else $error("masked event delivered");
  temp_link_a: assert property (s.st == cmd_pkg::S_STAT && !s.ev_v && cmd_ok
                                && s.opc == cmd_pkg::OPC_NAME && !conn_exists_in
                                |=> lm_temp_link_out && lm_req_out)
    else $error("no temporary link for name fetch");
  name_once_a: assert property (s.st == cmd_pkg::S_DONE && !s.ev_v
                                |=> s.st == cmd_pkg::S_IDLE [*2])
    else $error("completion issued more than once");
  mkey_handle_a: assert property ($rose(s.ev_v) && $past(s.st) == cmd_pkg::S_DONE
                                  && s.ev_code == cmd_pkg::EVT_MKEY_DONE
                                  |-> s.ev_hdl == s.lm_hdl)
    else $error("key select complete has wrong handle");
  note_order_a: assert property (s.st == cmd_pkg::S_NOTE && !s.ev_v
                                 |=> s.st == cmd_pkg::S_DONE)
    else $error("key notice not followed by completion");
endmodule : cmd_ctrl
`default_nettype wire

/* File: rtl/cmd_pkg.sv */
// Constants and types shared by the link key and peer name command engine
package cmd_pkg;
  // ----------------------------------------
  // Opcode fields and parameter ranges
  // ----------------------------------------
  localparam int OPC_W = 16;
  localparam int HDL_W = 12;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 48;
  localparam int OFS_W = 15;
  localparam int OFS_VALID_BIT = 15;
  localparam logic [15:0] OPC_REKEY = 16'h0015;
  localparam logic [15:0] OPC_KEYSEL = 16'h0017;
  localparam logic [15:0] OPC_NAME = 16'h0019;
  localparam logic [11:0] HDL_MAX = 12'hEFF;
  localparam logic [7:0] KEY_SEMI = 8'h00;
  localparam logic [7:0] KEY_TEMP = 8'h01;
  localparam logic [7:0] REP_MAX = 8'h02;
  localparam logic [7:0] SCAN_MAX = 8'h03;
  // ----------------------------------------
  // Register byte offsets and field positions
  // ----------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_HANDLE = 8'h04;
  localparam logic [7:0] REG_KEY = 8'h08;
  localparam logic [7:0] REG_ADDR_LO = 8'h0C;
  localparam logic [7:0] REG_ADDR_HI = 8'h10;
  localparam logic [7:0] REG_SCAN = 8'h14;
  localparam logic [7:0] REG_OFS = 8'h18;
  localparam logic [7:0] REG_MASK = 8'h1C;
  localparam logic [7:0] REG_EVT = 8'h20;
  localparam logic [7:0] REG_EVT_HDL = 8'h24;
  localparam logic [7:0] REG_STATE = 8'h28;
  localparam int CMD_BUSY_BIT = 16;
  localparam int SCAN_LSB = 8;
  localparam int EVT_STAT_LSB = 16;
  localparam int EVT_VALID_BIT = 31;
  localparam int STATE_KEY_BIT = 0;
  localparam int STATE_FSM_LSB = 1;
  // ----------------------------------------
  // Events, mask bits and status codes
  // ----------------------------------------
  localparam logic [7:0] EVT_STATUS = 8'h01;
  localparam logic [7:0] EVT_KEY_NOTE = 8'h02;
  localparam logic [7:0] EVT_REKEY_DONE = 8'h03;
  localparam logic [7:0] EVT_MKEY_DONE = 8'h04;
  localparam logic [7:0] EVT_NAME_DONE = 8'h05;
  localparam logic [7:0] EVT_CMD_DONE = 8'h0F;
  localparam int MASK_W = 5;
  localparam int MB_STATUS = 0;
  localparam int MB_NOTE = 1;
  localparam int MB_REKEY = 2;
  localparam int MB_MKEY = 3;
  localparam int MB_NAME = 4;
  localparam logic [4:0] MASK_RST = 5'h1F;
  localparam logic [7:0] STS_OK = 8'h00;
  localparam logic [7:0] STS_UNKNOWN = 8'h01;
  localparam logic [7:0] STS_BAD_PARAM = 8'h02;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_STAT = 3'b001,
    S_LM = 3'b010,
    S_NOTE = 3'b011,
    S_DONE = 3'b100
  } fsm_t;
endpackage : cmd_pkg

/* File: rtl/cmd_param_check.sv */
// Parameter range check for the three command opcodes
`timescale 1ns/1ps
`default_nettype none
module cmd_param_check (
  // Captured command
  input wire logic [15:0] opc_in,
  input wire logic [11:0] hdl_in,
  input wire logic [7:0] kflag_in,
  input wire logic [7:0] rep_in,
  input wire logic [7:0] scan_in,
  // Verdict
  output logic known_out,
  output logic ok_out
);
  logic hdl_ok;
  logic key_ok;
  logic mode_ok;

  // ----------------------------------------
  // Field ranges
  // ----------------------------------------
  // Only the low 12 bits are kept, so upper bits never matter
  assign hdl_ok = (hdl_in <= cmd_pkg::HDL_MAX);
  assign key_ok = (kflag_in <= cmd_pkg::KEY_TEMP);
  assign mode_ok = (rep_in <= cmd_pkg::REP_MAX)
                   && (scan_in <= cmd_pkg::SCAN_MAX);

  // Per opcode verdict
  always_comb begin
    known_out = 1'b1;
    ok_out = 1'b0;
    case (opc_in)
      cmd_pkg::OPC_REKEY: ok_out = hdl_ok;
      cmd_pkg::OPC_KEYSEL: ok_out = key_ok;
      cmd_pkg::OPC_NAME: ok_out = mode_ok;
      default: known_out = 1'b0;
    endcase
  end
endmodule : cmd_param_check
`default_nettype wire

/* File: tb/lm_model.sv */
// Behavioural link manager that answers the command engine's requests
`timescale 1ns/1ps
`default_nettype none
module lm_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Request side and bench controls
  input wire logic req_in,
  input wire logic slow_in,
  input wire logic peer_go_in,
  input wire logic [11:0] hdl_in,
  // Answers
  output logic done_out,
  output logic [7:0] status_out,
  output logic [11:0] handle_out,
  output logic peer_rekey_out,
  output logic peer_keysel_out
);
  logic [4:0] cnt_r;
  logic [7:0] junk_r;
  // ----------------------------------------
  // Answer timing
  // ----------------------------------------
  // One done pulse per request, prompt or slow
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r <= 5'h00;
      done_out <= 1'b0;
      peer_keysel_out <= 1'b0;
      peer_rekey_out <= 1'b0;
      junk_r <= 8'h00;
    end else begin
      // Slow selects which remote event a peer strobe stands for
      peer_keysel_out <= peer_go_in && !slow_in;
      peer_rekey_out <= peer_go_in && slow_in;
      junk_r <= junk_r + 8'h01;
      if (req_in && !done_out) begin
        cnt_r <= cnt_r + 5'h01;
        if (cnt_r == (slow_in ? 5'h14 : 5'h01)) begin
          done_out <= 1'b1;
          cnt_r <= 5'h00;
        end
      end else begin
        done_out <= 1'b0;
      end
    end
  end
  // Answer fields only hold meaning with a pulse; otherwise they churn
  assign status_out = (done_out || peer_keysel_out || peer_rekey_out) ? 8'h00 : junk_r;
  assign handle_out = (done_out || peer_keysel_out || peer_rekey_out) ? hdl_in : ~hdl_in;
endmodule : lm_model
`default_nettype wire

/* File: tb/cmd_ctrl_tb_top.sv */
// Register level bench for the command engine
`timescale 1ns/1ps
`default_nettype none
module cmd_ctrl_tb_top;
  logic clk, rst_b, rd_r, wr_r, slow, peer_go, is_master, enc_act, conn;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [11:0] hdl, lm_hdl;
  logic [7:0] lm_sts, rep, scn, rcl, smd;
  logic [15:0] opc;
  logic [47:0] dev;
  logic [14:0] ofs;
  logic req, done, ktemp, restart, evt_v, wait_r, tlink, ofs_v, prk, pks;
  int err_count, n_tests;
  int restarts = 0;
  // ----------------------------------------
  // Clock, design and link manager
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  cmd_ctrl dut (.core_clk_in(clk), .rst_b_in(rst_b), .avm_address_in(addr),
    .avm_read_in(rd_r), .avm_write_in(wr_r), .avm_writedata_in(wdata),
    .avm_byteenable_in(4'hF), .avm_readdata_out(rdata), .avm_waitrequest_out(wait_r),
    .lm_req_out(req), .lm_opcode_field_out(opc), .lm_handle_out(), .lm_device_address_out(dev),
    .lm_repeat_class_out(rcl), .lm_scan_mode_out(smd), .lm_clock_offset_out(ofs),
    .lm_offset_valid_out(ofs_v), .lm_temp_link_out(tlink), .lm_key_temp_out(ktemp),
    .enc_restart_out(restart), .lm_done_in(done), .lm_status_in(lm_sts), .lm_handle_in(lm_hdl),
    .is_master_in(is_master), .enc_active_in(enc_act), .conn_exists_in(conn),
    .peer_rekey_in(prk), .peer_keysel_in(pks), .evt_valid_out(evt_v));
  lm_model lm (.core_clk_in(clk), .rst_b_in(rst_b), .req_in(req), .slow_in(slow),
    .peer_go_in(peer_go), .hdl_in(hdl), .done_out(done), .status_out(lm_sts),
    .handle_out(lm_hdl), .peer_rekey_out(prk), .peer_keysel_out(pks));
  // Restart pulses counted so a missing or doubled one shows
  always @(posedge clk) if (restart === 1'b1) restarts <= restarts + 1;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_r <= w;
    rd_r <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    r = rdata;
    wr_r <= 1'b0;
    rd_r <= 1'b0;
    if (n >= 50) begin
      err_count++;
      $display("Error %0t: bus timeout", $time);
      tally_and_finish();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  // Wait for an event, compare it, then pop it
  task automatic evt(input logic [7:0] code, input logic [7:0] st);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (evt_v !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_count++;
      $display("Error %0t: event timeout", $time);
      tally_and_finish();
    end
    bus(1'b0, cmd_pkg::REG_EVT, 32'h0, r);
    chk(r & 32'h80FF00FF, {32'h80, st, 8'h00, code});
    if (code === cmd_pkg::EVT_MKEY_DONE) begin
      bus(1'b0, cmd_pkg::REG_EVT_HDL, 32'h0, r);
      chk(r[11:0], hdl);
    end
    wr(cmd_pkg::REG_EVT, 32'h0);
  endtask : evt
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b, rd_r, wr_r, slow, peer_go, is_master, enc_act, conn} = 8'h00;
    {addr, wdata, hdl, err_count, n_tests} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, cmd_pkg::REG_MASK, 32'h0, q);
    chk(q, 32'h1F);
    bus(1'b0, 8'h30, 32'h0, q);
    chk(q, 32'h0);
    // Slow rekey at the top valid handle; a write while busy is ignored
    slow <= 1'b1;
    wr(cmd_pkg::REG_HANDLE, 32'h0EFF);
    wr(cmd_pkg::REG_CMD, 32'h0015);
    wr(cmd_pkg::REG_HANDLE, 32'h0123);
    evt(cmd_pkg::EVT_STATUS, cmd_pkg::STS_OK);
    chk({req, opc, dut.lm_handle_out}, {1'b1, 16'h0015, 12'hEFF});
    evt(cmd_pkg::EVT_KEY_NOTE, cmd_pkg::STS_OK);
    evt(cmd_pkg::EVT_REKEY_DONE, cmd_pkg::STS_OK);
    // Refusals: first reserved handle, unknown opcode, reserved key flag
    slow <= 1'b0;
    wr(cmd_pkg::REG_HANDLE, 32'h0F00);
    wr(cmd_pkg::REG_CMD, 32'h0015);
    evt(cmd_pkg::EVT_STATUS, cmd_pkg::STS_BAD_PARAM);
    chk(req, 1'b0);
    wr(cmd_pkg::REG_CMD, 32'h0016);
    evt(cmd_pkg::EVT_STATUS, cmd_pkg::STS_UNKNOWN);
    wr(cmd_pkg::REG_KEY, 32'h02);
    wr(cmd_pkg::REG_CMD, 32'h0017);
    evt(cmd_pkg::EVT_STATUS, cmd_pkg::STS_BAD_PARAM);
    // Each key type, then a master rekey with encryption on; only the temporary key restarts it
    hdl <= 12'h5A5;
    for (int k = 1; k >= 0; k--) begin
      wr(cmd_pkg::REG_KEY, k);
      wr(cmd_pkg::REG_CMD, 32'h0017);
      evt(cmd_pkg::EVT_STATUS, cmd_pkg::STS_OK);
      evt(cmd_pkg::EVT_MKEY_DONE, cmd_pkg::STS_OK);
      bus(1'b0, cmd_pkg::REG_STATE, 32'h0, q);
      chk({q[0], ktemp}, {2{k[0]}});
      is_master <= 1'b1;
      enc_act <= 1'b1;
      wr(cmd_pkg::REG_HANDLE, 32'h0001);
      wr(cmd_pkg::REG_CMD, 32'h0015);
      evt(cmd_pkg::EVT_STATUS, cmd_pkg::STS_OK);
      evt(cmd_pkg::EVT_KEY_NOTE, cmd_pkg::STS_OK);
      evt(cmd_pkg::EVT_REKEY_DONE, cmd_pkg::STS_OK);
      chk(restarts, 1);
    end
    // Name fetch over every mode value from zero up to one past the limits
    slow <= 1'b1;
    wr(cmd_pkg::REG_ADDR_LO, 32'h89ABCDEF);
    wr(cmd_pkg::REG_ADDR_HI, 32'h4567);
    wr(cmd_pkg::REG_OFS, 32'h8123);
    for (int k = 0; k < 9; k++) begin
      conn <= k[0];
      rep = (k < 4) ? k : 0;
      scn = (k >= 4) ? k - 4 : 0;
      wr(cmd_pkg::REG_SCAN, {16'h0, scn, rep});
      wr(cmd_pkg::REG_CMD, 32'h0019);
      if (rep > 8'h02 || scn > 8'h03) begin
        evt(cmd_pkg::EVT_STATUS, cmd_pkg::STS_BAD_PARAM);
      end else begin
        evt(cmd_pkg::EVT_STATUS, cmd_pkg::STS_OK);
        chk({tlink, ofs_v, ofs}, {~k[0], 1'b1, 15'h0123});
        chk({dev, rcl, smd}, {48'h456789ABCDEF, rep, scn});
        evt(cmd_pkg::EVT_NAME_DONE, cmd_pkg::STS_OK);
      end
    end
    repeat (10) @(posedge clk);
    chk(evt_v, 1'b0);
    // Status masked away: only the later events of a rekey arrive
    wr(cmd_pkg::REG_MASK, 32'h1E);
    wr(cmd_pkg::REG_CMD, 32'h0015);
    evt(cmd_pkg::EVT_KEY_NOTE, cmd_pkg::STS_OK);
    evt(cmd_pkg::EVT_REKEY_DONE, cmd_pkg::STS_OK);
    // Remote key notice (slow high), then remote key select, on this side
    hdl <= 12'h321;
    for (int k = 1; k >= 0; k--) begin
      slow <= k[0];
      @(posedge clk);
      peer_go <= 1'b1;
      @(posedge clk);
      peer_go <= 1'b0;
      evt(k ? cmd_pkg::EVT_KEY_NOTE : cmd_pkg::EVT_MKEY_DONE, cmd_pkg::STS_OK);
    end
    tally_and_finish();
  end
endmodule : cmd_ctrl_tb_top
`default_nettype wire
